// File: src/ipc_pkg.sv
// Constants, types and helpers for the interrupt pending-clear block.
// Assumes one clock, one bus master port and a fixed two-processor build.

package ipc_pkg;

  // ****************************************************************
  // Build shape
  // ****************************************************************
  localparam int NCPU        = 2;
  localparam int CPU_W       = 1;
  localparam int LINE_GROUPS = 2;
  localparam int NSLOT       = NCPU * 32 + (LINE_GROUPS - 1) * 32;
  localparam int NUM_SGI     = 16;
  localparam int LOCK_FIRST  = 32;
  localparam int LOCK_COUNT  = 32;
  localparam logic        SEC_EXT   = 1'b1;
  localparam logic [63:0] IMPL_MASK = 64'h0fff_ffff_ffff_ffff;

  // ****************************************************************
  // Register map (byte offsets) and fields
  // ****************************************************************
  localparam logic [11:0] OFS_TYPE  = 12'h004;
  localparam logic [11:0] OFS_GROUP = 12'h080;
  localparam logic [11:0] OFS_SET   = 12'h200;
  localparam logic [11:0] OFS_CLR   = 12'h280;
  localparam logic [11:0] OFS_CFG   = 12'hc00;
  localparam logic [4:0]  TYPE_LINE_GROUPS = 5'h01;
  localparam logic [2:0]  TYPE_CPUS        = 3'h1;
  localparam int TYPE_LINES_LSB = 0;
  localparam int TYPE_CPU_LSB   = 5;
  localparam int TYPE_SEC_BIT   = 10;
  localparam logic RST_EDGE  = 1'b0;
  localparam logic RST_GROUP = 1'b0;

  typedef logic [31:0]      ipc_word_t;
  typedef logic [NSLOT-1:0] ipc_slot_t;

  // Gathers the 32 slot bits that one register word shows to one cpu
  function automatic ipc_word_t ipc_pick(input ipc_slot_t v,
                                         input logic [4:0] m,
                                         input logic [CPU_W-1:0] cpu);
    if (m == 5'h00) begin
      return v[int'(cpu) * 32 +: 32];
    end
    return v[NCPU * 32 + (int'(m) - 1) * 32 +: 32];
  endfunction

endpackage

// File: src/ipc_bus_if.sv
// Decoded register access passed from the bus front end to the registers.
// Assumes widx, ns and cpu stand for the whole data phase.
`timescale 1ns/1ps
`default_nettype none

interface ipc_bus_if;
  import ipc_pkg::*;
  logic             wr;
  logic             ns;
  logic [CPU_W-1:0] cpu;
  logic [9:0]       widx;
  ipc_word_t        wdata;
  ipc_word_t        rdata;
  modport front (output wr, ns, cpu, widx, wdata, input rdata);
  modport regs  (input wr, ns, cpu, widx, wdata, output rdata);
endinterface

`default_nettype wire

// File: src/ipc_ahb_front.sv
// AHB-Lite slave front end: word writes with no wait, reads with one wait.
// Assumes whole-word single transfers; the response is always OKAY.
`timescale 1ns/1ps
`default_nettype none

module ipc_ahb_front
  import ipc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  input  wire logic             hnonsec,
  input  wire logic [CPU_W-1:0] hmaster,
  output logic                  hreadyout,
  output ipc_word_t             hrdata,
  output logic                  hresp,
  ipc_bus_if.front              bus
);

  logic             ph_wr;
  logic             ph_rd;
  logic             ns_q;
  logic [CPU_W-1:0] cpu_q;
  logic [9:0]       widx_q;

  wire logic take = hsel & hready & htrans[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_wr  <= 1'b0;
      ph_rd  <= 1'b0;
      ns_q   <= 1'b0;
      cpu_q  <= '0;
      widx_q <= 10'h000;
      hrdata <= 32'h0000_0000;
    end else begin
      ph_wr <= take & hwrite;
      ph_rd <= take & ~hwrite;
      if (take) begin
        ns_q   <= hnonsec;
        cpu_q  <= hmaster;
        widx_q <= haddr[11:2];
      end
      if (ph_rd) begin
        hrdata <= bus.rdata;
      end
    end
  end

  // Read holds the bus one cycle so the read word comes from a flop
  assign hreadyout = ~ph_rd;
  assign hresp     = 1'b0;
  assign bus.wr    = ph_wr;
  assign bus.ns    = ns_q;
  assign bus.cpu   = cpu_q;
  assign bus.widx  = widx_q;
  assign bus.wdata = hwdata;

endmodule

`default_nettype wire

// File: src/ipc_pend_cell.sv
// Pending state of one interrupt for edge or level triggering.
// Assumes the line is synchronous and active high; set wins over clear.
`timescale 1ns/1ps
`default_nettype none

module ipc_pend_cell (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic edge_mode,
  input  wire logic line,
  input  wire logic sw_set,
  input  wire logic sw_clr,
  input  wire logic ack,
  output logic      pend
);

  logic line_q;
  logic latch;

  wire logic rise       = edge_mode & line & ~line_q;
  wire logic next_latch = (rise | sw_set) ? 1'b1 :
                          (sw_clr | ack)  ? 1'b0 :
                          latch;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_q <= 1'b0;
      latch  <= 1'b0;
    end else begin
      line_q <= line;
      latch  <= next_latch;
    end
  end

  // Level mode ORs in the raw line, so a clear cannot hide it
  assign pend = latch | (~edge_mode & line);

endmodule

`default_nettype wire

// File: src/ipc_pending_clear.sv
// Top of the pending-clear block: register file and per-interrupt cells.
// Assumes AHB-Lite with HMASTER naming the processor and HNONSEC security.
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module ipc_pending_clear
  import ipc_pkg::*;
(
  input  wire logic             CORE_CLK,
  input  wire logic             RESETN,
  input  wire logic             HSEL,
  input  wire logic [31:0]      HADDR,
  input  wire logic [1:0]       HTRANS,
  input  wire logic             HWRITE,
  input  wire logic [2:0]       HSIZE,
  input  wire logic [31:0]      HWDATA,
  input  wire logic             HREADY,
  input  wire logic             HNONSEC,
  input  wire logic [CPU_W-1:0] HMASTER,
  output logic                  HREADYOUT,
  output ipc_pkg::ipc_word_t    HRDATA,
  output logic                  HRESP,
  input  wire ipc_pkg::ipc_slot_t IRQ_LINE,
  input  wire ipc_pkg::ipc_slot_t IRQ_ACK,
  input  wire logic             CFG_LOCKDOWN,
  output ipc_pkg::ipc_slot_t    IRQ_PENDING
);
  import ipc_pkg::*;

  // ****************************************************************
  // Bus front end
  // ****************************************************************
  ipc_bus_if bus ();

  ipc_ahb_front u_front (
    .clk       (CORE_CLK),
    .rst_n     (RESETN),
    .hsel      (HSEL),
    .haddr     (HADDR),
    .htrans    (HTRANS),
    .hwrite    (HWRITE),
    .hwdata    (HWDATA),
    .hready    (HREADY),
    .hnonsec   (HNONSEC),
    .hmaster   (HMASTER),
    .hreadyout (HREADYOUT),
    .hrdata    (HRDATA),
    .hresp     (HRESP),
    .bus       (bus.front)
  );

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Each array starts on a 32-word boundary; index is the low 5 bits
  wire logic [4:0] reg_m  = bus.widx[4:0];
  wire logic       m_ok   = reg_m < 5'(LINE_GROUPS);
  wire logic       in_set = (bus.widx[9:5] == OFS_SET[11:7]) & m_ok;
  wire logic       in_clr = (bus.widx[9:5] == OFS_CLR[11:7]) & m_ok;
  wire logic       in_grp = (bus.widx[9:5] == OFS_GROUP[11:7]) & m_ok;
  wire logic       in_cfg = (bus.widx[9:5] == OFS_CFG[11:7]) & m_ok;
  wire logic       in_typ = (bus.widx == OFS_TYPE[11:2]);
  wire logic       ns_eff = SEC_EXT & bus.ns;

  ipc_slot_t sel;
  ipc_slot_t wbit;
  ipc_slot_t ok;
  ipc_slot_t impl_s;
  ipc_slot_t sgi_s;
  ipc_slot_t grp_ns;
  ipc_slot_t cfg_edge;
  ipc_slot_t pend;

  // ****************************************************************
  // Per-interrupt slots
  // ****************************************************************
  for (genvar s = 0; s < NSLOT; s++) begin : g_slot
    localparam int ID    = (s < NCPU * 32) ? s % 32 : s - (NCPU - 1) * 32;
    localparam int OWNER = s / 32;
    localparam logic LOCKABLE = (ID >= LOCK_FIRST)
                              && (ID < LOCK_FIRST + LOCK_COUNT);

    // Banked slots answer only their own processor
    assign sel[s]    = (reg_m == 5'(ID / 32))
                     & ((ID >= 32) | (bus.cpu == CPU_W'(OWNER)));
    assign wbit[s]   = bus.wdata[ID % 32];
    assign impl_s[s] = IMPL_MASK[ID];
    assign sgi_s[s]  = (ID < NUM_SGI);

    wire logic locked = CFG_LOCKDOWN & LOCKABLE & ~grp_ns[s];
    wire logic hidden = ns_eff & ~grp_ns[s];
    assign ok[s] = impl_s[s] & ~locked & ~hidden;

    wire logic wr_hit = bus.wr & sel[s] & wbit[s] & ok[s];
    wire logic set_p  = wr_hit & in_set & ~sgi_s[s];
    wire logic clr_p  = wr_hit & in_clr & ~sgi_s[s];

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
        cfg_edge[s] <= RST_EDGE;
        grp_ns[s]   <= RST_GROUP;
      end else begin
        if (bus.wr & in_cfg & sel[s] & ok[s] & ~sgi_s[s]) begin
          cfg_edge[s] <= wbit[s];
        end
        if (bus.wr & in_grp & sel[s] & impl_s[s] & ~ns_eff & ~locked) begin
          grp_ns[s] <= wbit[s];
        end
      end
    end

    // Software-generated slots are always edge: the line is the set pulse
    ipc_pend_cell u_cell (
      .clk       (CORE_CLK),
      .rst_n     (RESETN),
      .edge_mode (sgi_s[s] | cfg_edge[s]),
      .line      (IRQ_LINE[s]),
      .sw_set    (set_p),
      .sw_clr    (clr_p),
      .ack       (IRQ_ACK[s]),
      .pend      (pend[s])
    );
  end

  assign IRQ_PENDING = pend;

  // ****************************************************************
  // Read mux
  // ****************************************************************
  wire ipc_word_t vis     = ipc_pick(impl_s, reg_m, bus.cpu)
                          & (ns_eff ? ipc_pick(grp_ns, reg_m, bus.cpu)
                                    : 32'hffff_ffff);
  wire ipc_word_t rd_pend = ipc_pick(pend, reg_m, bus.cpu) & vis;
  wire ipc_word_t rd_cfg  = (ipc_pick(cfg_edge, reg_m, bus.cpu)
                          | ipc_pick(sgi_s, reg_m, bus.cpu)) & vis;
  wire ipc_word_t rd_grp  = ns_eff ? 32'h0000_0000
                          : ipc_pick(grp_ns, reg_m, bus.cpu)
                          & ipc_pick(impl_s, reg_m, bus.cpu);
  wire ipc_word_t rd_typ  = (32'(TYPE_LINE_GROUPS) << TYPE_LINES_LSB)
                          | (32'(TYPE_CPUS) << TYPE_CPU_LSB)
                          | (32'(SEC_EXT) << TYPE_SEC_BIT);

  assign bus.rdata = (in_set | in_clr) ? rd_pend :
                     in_cfg            ? rd_cfg  :
                     in_grp            ? rd_grp  :
                     in_typ            ? rd_typ  :
                     32'h0000_0000;

endmodule

`default_nettype wire

// File: verif/ipc_irq_src.sv
// Peripheral model driving the interrupt request lines.
// Assumes the bench asks for line levels; the lines follow one cycle later.
`timescale 1ns/1ps
`default_nettype none

module ipc_irq_src
  import ipc_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire ipc_slot_t want,
  output ipc_slot_t      line
);
  // Registered like a peripheral's own output flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line <= '0;
    end else begin
      line <= want;
    end
  end
endmodule

`default_nettype wire

// File: verif/ipc_pending_clear_monitor.sv
// Checker for the pending-clear block, bound to the top module.
// Assumes HREADY is tied to HREADYOUT and a single bus master.
`timescale 1ns/1ps
`default_nettype none

module ipc_pending_clear_monitor
  import ipc_pkg::*;
(
  input wire logic               CORE_CLK,
  input wire logic               RESETN,
  input wire logic               HSEL,
  input wire logic [1:0]         HTRANS,
  input wire logic               HWRITE,
  input wire logic               HREADY,
  input wire logic               HREADYOUT,
  input wire ipc_pkg::ipc_word_t HRDATA,
  input wire logic               HRESP,
  input wire ipc_pkg::ipc_slot_t IRQ_LINE,
  input wire ipc_pkg::ipc_slot_t IRQ_ACK,
  input wire ipc_pkg::ipc_slot_t IRQ_PENDING
);
  logic rd_a;
  logic wr_dp;
  wire  taken = HSEL & HREADY & HTRANS[1];
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rd_a <= 1'b0;
      wr_dp <= 1'b0;
    end else begin
      rd_a <= taken & ~HWRITE;
      wr_dp <= taken & HWRITE;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  property p_resp; HRESP == 1'b0; endproperty
  a_resp: assert property (p_resp) else $error("response not okay");
  property p_rd_wait; rd_a |-> !HREADYOUT ##1 HREADYOUT; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait");
  property p_rdy_hi; !rd_a |-> HREADYOUT; endproperty
  a_rdy_hi: assert property (p_rdy_hi) else $error("stray wait");
  property p_hold; $changed(HRDATA) |-> $past(rd_a); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_rose2; $rose(IRQ_LINE[2]) |=> IRQ_PENDING[2]; endproperty
  a_rose2: assert property (p_rose2) else $error("line 2 lost");
  property p_rose72; $rose(IRQ_LINE[72]) |=> IRQ_PENDING[72]; endproperty
  a_rose72: assert property (p_rose72) else $error("line 72 lost");
  property p_sgi_hold;
    IRQ_PENDING[2] && !IRQ_ACK[2] |=> IRQ_PENDING[2];
  endproperty
  a_sgi_hold: assert property (p_sgi_hold) else $error("sgi cleared");
  property p_cause;
    $rose(IRQ_PENDING[66]) |-> IRQ_LINE[66] || $past(IRQ_LINE[66]) ||
      $past(wr_dp);
  endproperty
  a_cause: assert property (p_cause) else $error("pending uncaused");
endmodule

bind ipc_pending_clear ipc_pending_clear_monitor mon (
  .CORE_CLK(CORE_CLK), .RESETN(RESETN), .HSEL(HSEL), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
  .HRDATA(HRDATA), .HRESP(HRESP), .IRQ_LINE(IRQ_LINE),
  .IRQ_ACK(IRQ_ACK), .IRQ_PENDING(IRQ_PENDING));

`default_nettype wire

// File: verif/tb_ipc_pending_clear.sv
// Self-checking bench for the pending-clear block over AHB-Lite.
// Assumes one master, HREADY fed back from HREADYOUT.
`timescale 1ns/1ps
`default_nettype none

module tb_ipc_pending_clear;
  import ipc_pkg::*;
  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             hsel = 1'b0;
  logic             hwrite = 1'b0;
  logic             hnonsec = 1'b0;
  logic             lock = 1'b0;
  logic             hrdy;
  logic             hresp;
  logic [1:0]       htrans = 2'h0;
  logic [31:0]      haddr = 32'h0;
  logic [31:0]      hwdata = 32'h0;
  logic [CPU_W-1:0] hmaster = '0;
  ipc_slot_t        want = '0;
  ipc_slot_t        ack = '0;
  ipc_slot_t        line;
  ipc_slot_t        pend;
  ipc_word_t        hrdata;
  int               bad_count = 0;
  int               n_tests = 0;
  always #5 clk = ~clk;

  ipc_irq_src src (.clk(clk), .rst_n(rst_n), .want(want), .line(line));
  ipc_pending_clear uut (
    .CORE_CLK(clk), .RESETN(rst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hrdy), .HNONSEC(hnonsec), .HMASTER(hmaster),
    .HREADYOUT(hrdy), .HRDATA(hrdata), .HRESP(hresp), .IRQ_LINE(line),
    .IRQ_ACK(ack), .CFG_LOCKDOWN(lock), .IRQ_PENDING(pend));

  // ****************************************************************
  // Bus and compare helpers
  // ****************************************************************
  task automatic bus(input logic w, input logic [11:0] a,
                     input ipc_word_t d, output ipc_word_t r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    @(posedge clk);
    while (!hrdy) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (!hrdy) @(posedge clk);
    r = hrdata;
  endtask
  task automatic chk(input string nm, input ipc_word_t e, input ipc_word_t g);
    n_tests++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  task automatic wr(input logic [11:0] a, input ipc_word_t d);
    ipc_word_t r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input ipc_word_t e);
    ipc_word_t r;
    bus(1'b0, a, 32'h0, r);
    chk(nm, e, r);
  endtask
  task automatic pin(input int s, input logic v);
    @(posedge clk);
    want[s] <= v;
    repeat (3) @(posedge clk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_type;
    rd("type", OFS_TYPE, 32'h0000_0421);
    rd("unmapped", 12'h300, 32'h0);
  endtask
  task automatic t_edge;
    wr(12'hc04, 32'h0000_0100);
    pin(72, 1'b1);
    pin(72, 0);
    rd("edge latch", 12'h284, 32'h100);
    wr(12'h284, 32'h0);
    rd("clear zero", 12'h284, 32'h100);
    wr(12'h284, 32'h100);
    rd("edge clear", 12'h284, 32'h0);
    wr(12'h204, 32'h100);
    rd("edge set", 12'h284, 32'h100);
    wr(12'h284, 32'h100);
    rd("set view", 12'h204, 32'h0);
    // Line rises in the clear write's data phase: the set must win
    fork
      wr(12'h284, 32'h100);
      begin
        @(posedge clk);
        want[72] <= 1'b1;
      end
    join
    pin(72, 1'b0);
    rd("set wins", 12'h284, 32'h100);
    wr(12'h284, 32'h100);
    rd("edge reclear", 12'h284, 32'h0);
  endtask
  task automatic t_level;
    pin(65, 1'b1);
    rd("level line", 12'h284, 32'h2);
    hmaster <= 1'b1;
    rd("shared view", 12'h284, 32'h2);
    hmaster <= 1'b0;
    wr(12'h284, 32'h2);
    rd("level held", 12'h284, 32'h2);
    pin(65, 1'b0);
    rd("level drop", 12'h284, 32'h0);
    wr(12'h204, 32'h2);
    rd("level latch", 12'h284, 32'h2);
    wr(12'h284, 32'h2);
    rd("level sw clr", 12'h284, 32'h0);
    wr(12'h204, 32'h2);
    pin(65, 1'b1);
    wr(12'h284, 32'h2);
    pin(65, 1'b0);
    rd("latch reset", 12'h284, 32'h0);
  endtask
  task automatic t_sgi;
    pin(2, 1'b1);
    pin(2, 1'b0);
    wr(12'h280, 32'h4);
    rd("sgi kept", 12'h280, 32'h4);
    hmaster <= 1'b1;
    rd("bank other", 12'h280, 32'h0);
    hmaster <= 1'b0;
    ack[2] <= 1'b1;
    @(posedge clk);
    ack[2] <= 1'b0;
    rd("sgi acked", 12'h280, 32'h0);
  endtask
  task automatic t_guard;
    wr(12'h204, 32'h4);
    hnonsec <= 1'b1;
    wr(12'h284, 32'h4);
    rd("ns view", 12'h284, 32'h0);
    hnonsec <= 1'b0;
    rd("secure kept", 12'h284, 32'h4);
    lock <= 1'b1;
    wr(12'h284, 32'h4);
    rd("locked", 12'h284, 32'h4);
    lock <= 1'b0;
    wr(12'h284, 32'h4);
    rd("unlocked", 12'h284, 32'h0);
    wr(12'h204, 32'hf800_0000);
    rd("unimpl", 12'h284, 32'h0800_0000);
    chk("flag", 32'h1, {31'h0, pend[91]});
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_type();
    t_edge();
    t_level();
    t_sgi();
    t_guard();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
endmodule

`default_nettype wire
